// >>> include/lcd_ctrl_regs.vh
/*
  Register offsets, field positions, reset values and decode codes for the
  LCD pin/duty and power/display control registers.
  Assumes a byte-wide register file reached over a 32-bit Avalon-MM slave,
  each register in the low byte of one aligned word.
*/
`ifndef LCD_CTRL_REGS_VH
`define LCD_CTRL_REGS_VH

`define LCD_ADDR_W 4
`define LCD_OFF_PIN_DUTY 4'h0
`define LCD_OFF_PWR_SHOW_RAM_DATA 4'h4

`define LCD_PIN_DUTY_RST 8'h00
`define LCD_PWR_SHOW_RAM_DATA_RST 8'h80
`define LCD_PWR_SHOW_RAM_DATA_WMASK 8'h7F

`define LCD_DUTY_HI_BIT 7
`define LCD_DUTY_LO_BIT 6
`define LCD_PARALLEL_BIT 5
`define LCD_EXPAND_BIT 4
`define LCD_POWER_BIT 6
`define LCD_ACTIVATE_BIT 5
`define LCD_SHOW_RAM_BIT 4

`define LCD_DUTY_STATIC 2'h0
`define LCD_DUTY_HALF 2'h1
`define LCD_DUTY_THIRD 2'h2
`define LCD_DUTY_QUARTER 2'h3

`define LCD_UNMAPPED_RDATA 32'h00000000
`define LCD_COM_SRC_IDENT 8'hE4

`endif

// >>> src/lcd_common_map.v
/*
  Common-pin enable and source map from duty and parallel bit.
  Assumes inputs are registered fields on the same clock.
*/
`timescale 1ns/10ps
`include "lcd_ctrl_regs.vh"
module lcd_common_map (
  input wire [1:0] duty_i,
  input wire common_parallel_i,
  output reg [3:0] com_en_o,
  output reg [7:0] com_src_o
);
  // Source per pin is a 2-bit index of the common phase it reproduces
  always @* begin
    com_en_o = 4'h1;
    com_src_o = `LCD_COM_SRC_IDENT;
    case (duty_i)
      `LCD_DUTY_STATIC: begin
        if (common_parallel_i) begin
          com_en_o = 4'hF;
          com_src_o = 8'h00;
        end else begin
          com_en_o = 4'h1;
        end
      end
      `LCD_DUTY_HALF: begin
        if (common_parallel_i) begin
          com_en_o = 4'hF;
          com_src_o = 8'hA0;
        end else begin
          com_en_o = 4'h3;
        end
      end
      `LCD_DUTY_THIRD: com_en_o = 4'h7;
      `LCD_DUTY_QUARTER: com_en_o = 4'hF;
      default: com_en_o = 4'h1;
    endcase
  end
endmodule // lcd_common_map

// >>> src/lcd_port_and_control_regs.v
/*
  Pin/duty and power/display control registers of the segment LCD
  controller, with decoded pin functions and supply control.
  Assumes an Avalon-MM master on mclk_i and a standby level from the chip's
  power manager arriving asynchronously.
*/
`timescale 1ns/10ps
`include "lcd_ctrl_regs.vh"
module lcd_port_and_control_regs (
  input wire mclk_i,
  input wire rst_i,
  input wire [`LCD_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire standby_i,
  output reg [1:0] duty_sel_o,
  output reg [3:0] common_en_o,
  output reg [7:0] common_src_o,
  output reg [31:0] seg_drive_en_o,
  output reg expansion_en_o,
  output reg drive_supply_on_o,
  output reg controller_run_o,
  output reg show_ram_data_o,
  output reg [3:0] frame_clk_sel_o
);
  reg [7:0] pin_duty_q;
  reg [7:0] pwr_show_ram_data_q;
  reg ack_q;
  reg [2:0] stby_sync_q;
  reg standby_q;
  wire [3:0] com_en;
  wire [7:0] com_src;
  wire [31:0] seg_en;
  wire exp_en;
  wire access;
  wire sel_pin;
  wire sel_pwr;
  wire activate;

  assign access = avs_read_i | avs_write_i;
  assign sel_pin = (avs_address_i == `LCD_OFF_PIN_DUTY);
  assign sel_pwr = (avs_address_i == `LCD_OFF_PWR_SHOW_RAM_DATA);
  assign activate = pwr_show_ram_data_q[`LCD_ACTIVATE_BIT];

  // One wait cycle: the access completes on the edge after ack rises
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access & ~ack_q;
    end
  end

  // Waitrequest is registered; high while a fresh request awaits its ack
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(access & ~ack_q);
    end
  end

  // Register writes, low byte lane only; reserved top bit held at one
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_duty_q <= `LCD_PIN_DUTY_RST;
      pwr_show_ram_data_q <= `LCD_PWR_SHOW_RAM_DATA_RST;
    end else if (avs_write_i & ack_q & avs_byteenable_i[0]) begin
      if (sel_pin) begin
        pin_duty_q <= avs_writedata_i[7:0];
      end
      if (sel_pwr) begin
        pwr_show_ram_data_q <= (avs_writedata_i[7:0] & `LCD_PWR_SHOW_RAM_DATA_WMASK)
                      | ~`LCD_PWR_SHOW_RAM_DATA_WMASK;
      end
    end
  end

  // Read data prepared alongside the ack; unmapped words read zero
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= `LCD_UNMAPPED_RDATA;
    end else if (avs_read_i & ~ack_q) begin
      if (sel_pin)
        avs_readdata_o <= {24'h000000, pin_duty_q};
      else if (sel_pwr)
        avs_readdata_o <= {24'h000000, pwr_show_ram_data_q | 8'h80};
      else
        avs_readdata_o <= `LCD_UNMAPPED_RDATA;
    end
  end

  // Standby arrives from another domain: three stages, two must agree
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stby_sync_q <= 3'h0;
      standby_q <= 1'b0;
    end else begin
      stby_sync_q <= {stby_sync_q[1:0], standby_i};
      if (stby_sync_q[1] == stby_sync_q[2])
        standby_q <= stby_sync_q[2];
    end
  end

  lcd_common_map u_common_map (
    .duty_i(pin_duty_q[`LCD_DUTY_HI_BIT:`LCD_DUTY_LO_BIT]),
    .common_parallel_i(pin_duty_q[`LCD_PARALLEL_BIT]),
    .com_en_o(com_en),
    .com_src_o(com_src)
  );

  lcd_seg_map u_seg_map (
    .seg_group_sel_i(pin_duty_q[3:0]),
    .expansion_select_i(pin_duty_q[`LCD_EXPAND_BIT]),
    .seg_en_o(seg_en),
    .expansion_en_o(exp_en)
  );

  // Decoded outputs; halting only gates outputs, register contents stay
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      duty_sel_o <= 2'h0;
      common_en_o <= 4'h0;
      common_src_o <= `LCD_COM_SRC_IDENT;
      seg_drive_en_o <= 32'h00000000;
      expansion_en_o <= 1'b0;
      drive_supply_on_o <= 1'b0;
      controller_run_o <= 1'b0;
      show_ram_data_o <= 1'b0;
      frame_clk_sel_o <= 4'h0;
    end else begin
      duty_sel_o <= pin_duty_q[`LCD_DUTY_HI_BIT:`LCD_DUTY_LO_BIT];
      common_en_o <= activate ? com_en : 4'h0;
      common_src_o <= com_src;
      seg_drive_en_o <= activate ? seg_en : 32'h00000000;
      expansion_en_o <= exp_en;
      drive_supply_on_o <= pwr_show_ram_data_q[`LCD_POWER_BIT] & activate
                           & ~standby_q;
      controller_run_o <= activate;
      show_ram_data_o <= pwr_show_ram_data_q[`LCD_SHOW_RAM_BIT];
      frame_clk_sel_o <= pwr_show_ram_data_q[3:0];
    end
  end
endmodule // lcd_port_and_control_regs

// >>> src/lcd_seg_map.v
/*
  Segment pin function map from the group field and expansion bit.
  Assumes software keeps the group field zero while expansion is set.
*/
`timescale 1ns/10ps
module lcd_seg_map (
  input wire [3:0] seg_group_sel_i,
  input wire expansion_select_i,
  output wire [31:0] seg_en_o,
  output wire expansion_en_o
);
  // Number of 8-pin groups, counted from the top, that drive segments
  function [2:0] groups;
    input [3:0] sel;
    begin
      if (sel[3])
        groups = 3'h4;
      else
        groups = {1'b0, sel[2:1]};
    end
  endfunction

  wire [2:0] n_grp;
  assign n_grp = expansion_select_i ? 3'h0 : groups(seg_group_sel_i);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : grp
      // Group g covers pins 8g+1..8g+8; top group is g=3
      assign seg_en_o[8*g+7:8*g] = (n_grp > (3 - g)) ? 8'hFF : 8'h00;
    end
  endgenerate

  assign expansion_en_o = expansion_select_i;
endmodule // lcd_seg_map

// >>> test/lcd_panel_model.sv
/* Passive panel load on the common and supply pins.
   Assumes the register block drives the panel directly. */
`timescale 1ns/10ps
module lcd_panel_model (
  input wire [3:0] common_en_i,
  input wire drive_supply_on_i,
  output wire glass_biased_o
);
  // Glass is biased only with supply and a driven common
  assign glass_biased_o = drive_supply_on_i & (|common_en_i);
endmodule // lcd_panel_model

// >>> test/lcd_port_and_control_regs_tb.sv
/* Self-checking bench for the LCD register block and panel model.
   Assumes the Avalon slave answers one cycle after taking a request. */
`timescale 1ns/10ps
module lcd_port_and_control_regs_tb;
  logic mclk_i, rst_i, avs_read_i, avs_write_i, standby_i;
  logic [3:0] avs_address_i, avs_byteenable_i, common_en_o, frame_clk_sel_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, seg_drive_en_o;
  logic [1:0] duty_sel_o;
  logic [7:0] common_src_o;
  logic avs_waitrequest_o, expansion_en_o, drive_supply_on_o;
  logic controller_run_o, show_ram_data_o, glass_biased_o;
  integer fail_count = 0, check_count = 0, i;
  // Pin/duty value, then expansion, common enables, sources, segments
  logic [55:0] rows [8] = '{56'h00_0_1_E4_00000000, 56'h21_0_F_00_00000000,
    56'h42_0_3_E4_FF000000, 56'h64_0_F_A0_FFFF0000, 56'h86_0_7_E4_FFFFFF00,
    56'hA8_0_7_E4_FFFFFFFF, 56'hC0_0_F_E4_00000000, 56'h10_1_1_E4_00000000};
  lcd_port_and_control_regs lcd_port_and_control_regs_inst (.mclk_i(mclk_i),
    .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .standby_i(standby_i),
    .duty_sel_o(duty_sel_o), .common_en_o(common_en_o),
    .common_src_o(common_src_o), .seg_drive_en_o(seg_drive_en_o),
    .expansion_en_o(expansion_en_o), .drive_supply_on_o(drive_supply_on_o),
    .controller_run_o(controller_run_o), .show_ram_data_o(show_ram_data_o),
    .frame_clk_sel_o(frame_clk_sel_o));
  lcd_panel_model lcd_panel_model_inst (.common_en_i(common_en_o),
    .drive_supply_on_i(drive_supply_on_o), .glass_biased_o(glass_biased_o));
  task chk(input logic [55:0] got, input logic [55:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low at an edge
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d,
    input logic [3:0] be);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    if (!w) chk(avs_readdata_o, {24'h0, d});
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task complete_run;
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Clock and reset; no input floats at time zero
  initial begin
    mclk_i = 0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial begin
    {rst_i, avs_read_i, avs_write_i, standby_i} = 4'h8;
    {avs_address_i, avs_byteenable_i, avs_writedata_i} = 0;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    acc(1, 4'h4, 8'h7A, 4'hF);
    acc(0, 4'h4, 8'hFA, 4'h0);
    chk({drive_supply_on_o, controller_run_o, show_ram_data_o,
      frame_clk_sel_o}, 7'h7A);
    for (i = 0; i < 8; i = i + 1) begin
      acc(1, 4'h0, rows[i][55:48], 4'hF);
      acc(0, 4'h0, rows[i][55:48], 4'hF);
      chk({duty_sel_o, 3'h0, expansion_en_o, common_en_o, common_src_o,
        seg_drive_en_o},
        {rows[i][55:54], rows[i][47:0]});
    end
    chk(glass_biased_o, 1'b1);
    standby_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk(drive_supply_on_o, 1'b0);
    standby_i <= 1'b0;
    acc(1, 4'h4, 8'h50, 4'hF);
    acc(0, 4'h0, 8'h10, 4'hF);
    chk({drive_supply_on_o, controller_run_o, show_ram_data_o, common_en_o,
      seg_drive_en_o}, {3'h1, 36'h0});
    acc(1, 4'h0, 8'hFF, 4'h0);
    acc(0, 4'h0, 8'h10, 4'hF);
    acc(0, 4'h8, 8'h00, 4'hF);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    acc(0, 4'h0, 8'h00, 4'hF);
    acc(0, 4'h4, 8'h80, 4'hF);
    complete_run;
  end
  // Watchdog well beyond the 85 or so cycles the run needs
  initial begin
    repeat (3000) @(posedge mclk_i);
    fail_count = fail_count + 1;
    complete_run;
  end
endmodule // lcd_port_and_control_regs_tb

// >>> test/lcd_regs_asserts.sv
/* Port checks for the LCD pin/duty and power/display registers.
   Assumes binding to lcd_port_and_control_regs. */
`timescale 1ns/10ps
module lcd_regs_asserts (
  input wire mclk_i,
  input wire rst_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire [1:0] duty_sel_o,
  input wire [3:0] common_en_o,
  input wire [7:0] common_src_o,
  input wire [31:0] seg_drive_en_o,
  input wire expansion_en_o,
  input wire drive_supply_on_o,
  input wire controller_run_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wait_pulse_a: assert property (!avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("wait low too long");
  bus_answer_a: assert property ($rose(avs_read_i | avs_write_i)
    |-> ##[1:2] !avs_waitrequest_o) else $error("no answer");
  read_bits_a: assert property (!avs_waitrequest_o && avs_read_i
    |-> avs_readdata_o[31:8] == 0 && (avs_address_i != 4 || avs_readdata_o[7]))
    else $error("bad read bits");
  supply_gate_a: assert property (drive_supply_on_o
    |-> controller_run_o || $past(controller_run_o)) else $error("supply on");
  halt_off_a: assert property (!controller_run_o
    && !$past(controller_run_o) |-> common_en_o == 0 && seg_drive_en_o == 0)
    else $error("halt drives");
  seg_group_a: assert property (seg_drive_en_o inside {32'h0,
    32'hFF000000, 32'hFFFF0000, 32'hFFFFFF00, 32'hFFFFFFFF})
    else $error("bad group");
  exp_port_a: assert property (expansion_en_o |-> seg_drive_en_o == 0)
    else $error("segments in expansion");
  parallel_off_a: assert property (duty_sel_o[1] && $stable(duty_sel_o)
    |-> common_src_o == 8'hE4) else $error("copy at high duty");
  static_com_a: assert property (controller_run_o && duty_sel_o == 0
    && $stable(duty_sel_o) |-> common_en_o inside {4'h1, 4'hF})
    else $error("static commons");
  cover property (expansion_en_o);
  cover property (drive_supply_on_o);
  cover property (!avs_waitrequest_o && avs_write_i);
endmodule // lcd_regs_asserts
bind lcd_port_and_control_regs lcd_regs_asserts lcd_regs_asserts_inst (
  .mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .duty_sel_o, .common_en_o,
  .common_src_o, .seg_drive_en_o, .expansion_en_o, .drive_supply_on_o,
  .controller_run_o);
